// file: dv/tb_top.sv
/*
  Self-checking bench for udsf_status_frame with a register model.
  Assumes udsf_host_model stands for the USB host.
*/
`timescale 1ns/1ns
`include "udsf_map.svh"
`define CHK(n, e, g) begin comparisons++; if ((e) !== (g)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end

module tb_top;
  import udsf_pkg::*;
  logic         clk = 0, rst = 1, wr = 0, rd = 0, vb = 0, id = 0, vie = 1, iie = 1, rvalid;
  udsf_word_t   addr = '0, wdata = '0, rdata;
  logic [1:0]   ls = '0, tie = '0, sreq = '0, rreq = '0, sof_p, fvld, urst, tmo;
  udsf_frame_t  fnum = '0;
  udsf_frame2_t frm;
  udsf_ep2_t    ep [6] = '{default: '0};
  udsf_ep2_t    nie = '0;
  int           st [2] = '{0, 0}, fr [2] = '{0, 0}, error_cnt = 0, comparisons = 0;
  int           seed = 60984, n, n1, cyc;

  udsf_status_frame u_udsf_status_frame (.i_core_clk(clk), .i_rst(rst), .i_hp_addr(addr),
    .i_hp_wr(wr), .i_hp_rd(rd), .i_hp_wdata(wdata), .o_hp_rdata(rdata), .o_hp_rvalid(rvalid),
    .i_vbus_valid(vb), .i_otg_id(id), .i_vbus_ie(vie), .i_id_ie(iie), .i_sof_eop(sof_p),
    .i_sof_frame_vld(fvld), .i_sof_frame(frm), .i_low_speed(ls), .i_usb_reset(urst),
    .i_sof_tmo_ie(tie), .i_ep_ack(ep[0]), .i_ep_stall(ep[1]), .i_ep_tmo(ep[2]),
    .i_ep_in_err(ep[3]), .i_ep_out_err(ep[4]), .i_ep_nak(ep[5]), .i_ep_nak_ie(nie),
    .o_sof_timeout(tmo));
  udsf_host_model u_udsf_host_model (.i_core_clk(clk), .i_sof_req(sreq), .i_rst_req(rreq),
    .i_frame_num(fnum), .o_sof_eop(sof_p), .o_sof_frame_vld(fvld), .o_sof_frame(frm),
    .o_usb_reset(urst));

  initial forever #4 clk = ~clk;

  task automatic step(); @(posedge clk); #1; endtask : step
  task automatic rd_chk(input udsf_word_t a, input udsf_word_t e);
    step(); addr = a; rd = 1;
    step(); rd = 0;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask : rd_chk
  task automatic wr_w(input udsf_word_t a, input udsf_word_t d);
    step(); addr = a; wdata = d; wr = 1;
    step(); wr = 0;
  endtask : wr_w
  task automatic chk_all();
    for (int d = 0; d < 2; d++) begin
      rd_chk(d ? `UDSF_STATUS_ADDR1 : `UDSF_STATUS_ADDR0, udsf_word_t'(st[d]));
      rd_chk(d ? `UDSF_FRAME_ADDR1 : `UDSF_FRAME_ADDR0, udsf_word_t'(fr[d]));
    end
  endtask : chk_all
  task automatic clr(input int d, input udsf_word_t c);
    udsf_word_t m;
    m = d ? `UDSF_ST_MASK_DEV2 : `UDSF_ST_MASK_DEV1;
    wr_w(d ? `UDSF_STATUS_ADDR1 : `UDSF_STATUS_ADDR0, c & m);
    st[d] = st[d] & ~int'(c & m);
  endtask : clr
  task automatic ep_ev(input int k);
    udsf_word_t v;
    v = udsf_word_t'($random(seed));
    nie = udsf_word_t'($random(seed));
    ep[k] = v;
    step(); ep[k] = '0;
    if (k == 5) v = v & nie;
    st[0] |= int'(v[7:0]);
    st[1] |= int'(v[15:8]);
  endtask : ep_ev
  task automatic sof(input int d);
    fnum = udsf_frame_t'($random(seed));
    sreq[d] = 1;
    step(); sreq = '0;
    step();
    st[d] |= 32'h200;
    if (tie[d]) fr[d] &= 32'h07ff;
    if (!ls[d]) fr[d] = (fr[d] & 32'hf800) | int'(fnum);
  endtask : sof
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 0;
    wr_w(`UDSF_FRAME_ADDR0, 16'hffff);
    chk_all();
    rd_chk(`UDSF_COUNT_ADDR0, 16'h0000);
    rd_chk(`UDSF_COUNT_ADDR1, 16'h0000);
    rd_chk(16'hc096, 16'h0000);
    $display("test reset done");
    repeat (2) for (int k = 0; k < 6; k++) begin
      ep_ev(k);
      chk_all();
      clr(0, udsf_word_t'($random(seed)));
      clr(1, udsf_word_t'($random(seed)));
    end
    chk_all();
    $display("test endpoints done");
    vb = 1;
    step(); id = 1;
    step(); st[0] |= 32'hc000;
    chk_all();
    vie = 0; iie = 0; vb = 0;
    step(); id = 0;
    step(); chk_all();
    clr(0, 16'hffff);
    // rise while disabled, then fall with the enables on: only the fall counts
    vb = 1; id = 1;
    step(); vie = 1; iie = 1; vb = 0; id = 0;
    step(); st[0] |= 32'hc000;
    chk_all();
    clr(0, 16'hffff);
    $display("test otg done");
    rreq = 2'b01;
    step(); rreq = '0; addr = `UDSF_STATUS_ADDR0; wdata = 16'h0100; wr = 1;
    step(); wr = 0; st[0] |= 32'h100;
    chk_all();
    clr(0, 16'h0100);
    sof(0); sof(1); ls = 2'b10; sof(1);
    chk_all();
    ls = '0;
    $display("test events done");
    tie = 2'b11;
    wr_w(`UDSF_COUNT_ADDR0, 16'h0004);
    wr_w(`UDSF_COUNT_ADDR1, 16'h0004);
    n = 0;
    n1 = 0;
    for (cyc = 0; cyc < 3000 && (n < 8 || n1 < 8); cyc++) begin
      step(); n += tmo[0]; n1 += tmo[1];
    end
    if (n < 8 || n1 < 8) begin
      error_cnt++;
      print_verdict();
    end
    `CHK("tmo_span", 1'b1, cyc > 250 && cyc < 420)
    fr[0] |= 32'hf000;
    fr[1] |= 32'hf000;
    tie = '0;
    repeat (100) step();
    chk_all();
    wr_w(`UDSF_COUNT_ADDR0, 16'h3fff);
    wr_w(`UDSF_COUNT_ADDR1, 16'h3fff);
    tie = 2'b11;
    sof(0); sof(1);
    chk_all();
    $display("test timeout done");
    print_verdict();
  end
endmodule : tb_top

// file: dv/udsf_host_model.sv
/*
  Behavioural USB host: SOF/EOP tokens with frame number, and bus resets.
  Assumes one-cycle requests from the bench; answers one cycle later.
*/
`timescale 1ns/1ns

module udsf_host_model (
  input  wire logic                  i_core_clk,
  input  wire logic [1:0]            i_sof_req,
  input  wire logic [1:0]            i_rst_req,
  input  wire udsf_pkg::udsf_frame_t i_frame_num,
  output logic [1:0]                 o_sof_eop,
  output logic [1:0]                 o_sof_frame_vld,
  output udsf_pkg::udsf_frame2_t     o_sof_frame,
  output logic [1:0]                 o_usb_reset
);
  import udsf_pkg::*;
  // outside a token the frame lines show the inverse, so a stale number cannot be taken
  always @(posedge i_core_clk) begin
    o_sof_eop       <= i_sof_req;
    o_sof_frame_vld <= i_sof_req;
    o_usb_reset     <= i_rst_req;
    o_sof_frame     <= (|i_sof_req) ? {i_frame_num, i_frame_num}
                                    : ~{i_frame_num, i_frame_num};
  end
endmodule : udsf_host_model

// file: dv/udsf_monitor.sv
/*
  Checker for the host port answers and first instance timeout pulses of udsf_status_frame.
  Assumes a bind onto that module; one clock domain.
*/
`timescale 1ns/1ns
`include "udsf_map.svh"

module udsf_monitor (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst,
  input  wire udsf_pkg::udsf_word_t i_hp_addr,
  input  wire logic                 i_hp_rd,
  input  wire udsf_pkg::udsf_word_t o_hp_rdata,
  input  wire logic                 o_hp_rvalid,
  input  wire logic [1:0]           i_sof_tmo_ie,
  input  wire logic [1:0]           o_sof_timeout
);
  import udsf_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  property p_rv; i_hp_rd |=> o_hp_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_no_rv; !i_hp_rd |=> !o_hp_rvalid; endproperty
  a_no_rv: assert property (p_no_rv) else $error("answer without read");
  property p_hold; !i_hp_rd |=> $stable(o_hp_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_st0; i_hp_rd && i_hp_addr == `UDSF_STATUS_ADDR0
    |=> (o_hp_rdata & ~`UDSF_ST_MASK_DEV1) == `UDSF_WORD_ZERO; endproperty
  a_st0: assert property (p_st0) else $error("reserved status bit set");
  property p_st1; i_hp_rd && i_hp_addr == `UDSF_STATUS_ADDR1
    |=> (o_hp_rdata & ~`UDSF_ST_MASK_DEV2) == `UDSF_WORD_ZERO; endproperty
  a_st1: assert property (p_st1) else $error("second status top bits set");
  property p_cnt; i_hp_rd && (i_hp_addr == `UDSF_COUNT_ADDR0 || i_hp_addr == `UDSF_COUNT_ADDR1)
    |=> o_hp_rdata == `UDSF_WORD_ZERO; endproperty
  a_cnt: assert property (p_cnt) else $error("count register readable");
  property p_unmap; i_hp_rd && i_hp_addr == 16'hc096 |=> o_hp_rdata == `UDSF_WORD_ZERO;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_fr11; i_hp_rd && (i_hp_addr == `UDSF_FRAME_ADDR0 || i_hp_addr == `UDSF_FRAME_ADDR1)
    |=> !o_hp_rdata[11]; endproperty
  a_fr11: assert property (p_fr11) else $error("frame bit 11 set");
  property p_tmo_one; o_sof_timeout[0] |=> !o_sof_timeout[0]; endproperty
  a_tmo_one: assert property (p_tmo_one) else $error("timeout pulse too long");
  property p_tmo_ie;
    o_sof_timeout[0] |-> $past(i_sof_tmo_ie[0]) || $past(i_sof_tmo_ie[0], 2);
  endproperty
  a_tmo_ie: assert property (p_tmo_ie) else $error("timeout while disabled");

  c_rd: cover property (o_hp_rvalid && o_hp_rdata != `UDSF_WORD_ZERO);
  c_tmo: cover property (o_sof_timeout[0]);
  c_unmap: cover property (i_hp_rd && i_hp_addr == 16'hc096);
endmodule : udsf_monitor

bind udsf_status_frame udsf_monitor u_udsf_monitor (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_hp_addr(i_hp_addr), .i_hp_rd(i_hp_rd),
  .o_hp_rdata(o_hp_rdata), .o_hp_rvalid(o_hp_rvalid), .i_sof_tmo_ie(i_sof_tmo_ie),
  .o_sof_timeout(o_sof_timeout));

// file: hdl/udsf_sof_timer.sv
/*
  SOF/EOP interval down counter for one device instance.
  Assumes i_tick is a one-cycle pulse at the 12 MHz rate and i_restart
  marks each received SOF/EOP.
*/
`timescale 1ns/1ns
`include "udsf_map.svh"

module udsf_sof_timer (
  input  wire logic                i_core_clk,
  input  wire logic                i_rst,
  input  wire logic                i_tick,
  input  wire logic                i_restart,
  input  wire logic                i_load,
  input  wire udsf_pkg::udsf_count_t i_load_val,
  output logic                     o_timeout
);
  import udsf_pkg::*;

  udsf_count_t reload_q;
  udsf_count_t cnt_q;
  logic        timeout_q;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      reload_q <= `UDSF_COUNT_RESET;
    end else if (i_load) begin
      reload_q <= i_load_val;
    end
  end

  // a timeout reloads and keeps running, so repeated misses keep counting
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt_q     <= `UDSF_COUNT_RESET;
      timeout_q <= 1'b0;
    end else begin
      timeout_q <= 1'b0;
      if (i_load) begin
        cnt_q <= i_load_val;
      end else if (i_restart) begin
        cnt_q <= reload_q;
      end else if (i_tick) begin
        if (cnt_q <= `UDSF_COUNT_ONE) begin
          cnt_q     <= reload_q;
          timeout_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - `UDSF_COUNT_ONE;
        end
      end
    end
  end

  assign o_timeout = timeout_q;
endmodule : udsf_sof_timer

// file: hdl/udsf_status_frame.sv
/*
  Device status, frame number and SOF/EOP count registers for the two
  device instances of a USB peripheral engine, reached over the parallel
  host port.
  Assumes all inputs are synchronous to i_core_clk, event inputs are
  one-cycle pulses, and enables come from registers held elsewhere.
*/
// Functional notes
// - writing one clears a status flag
// - status register read/write over host port
// - VBUS flag on both 4.4V crossings
// - VBUS and ID flags first instance only
// - ID flag on both ID pin edges
// - bit 9 set on SOF/EOP received
// - bit 8 set on USB bus reset
// - endpoint flags on ACK/STALL/timeout/exception
// - NAK also sets flag when enabled
// - read-only frame number registers per instance
// - frame register carries timeout count
// - frame bit 15 flags SOF/EOP timeout
// - write-only interval count registers per instance
// - status register addresses per instance
// - 3-bit timeout counter, cleared by SOF/EOP
// - interval counter decrements at 12 MHz
// - frame keeps last value on timeout
`timescale 1ns/1ns
`include "udsf_map.svh"

module udsf_status_frame (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst,
  // parallel host port
  input  wire udsf_pkg::udsf_word_t   i_hp_addr,
  input  wire logic                   i_hp_wr,
  input  wire logic                   i_hp_rd,
  input  wire udsf_pkg::udsf_word_t   i_hp_wdata,
  output udsf_pkg::udsf_word_t        o_hp_rdata,
  output logic                        o_hp_rvalid,
  // first_otg_port sense and its interrupt enables
  input  wire logic                   i_vbus_valid,
  input  wire logic                   i_otg_id,
  input  wire logic                   i_vbus_ie,
  input  wire logic                   i_id_ie,
  // per instance bus events, bit d is instance d
  input  wire logic [1:0]             i_sof_eop,
  input  wire logic [1:0]             i_sof_frame_vld,
  input  wire udsf_pkg::udsf_frame2_t i_sof_frame,
  input  wire logic [1:0]             i_low_speed,
  input  wire logic [1:0]             i_usb_reset,
  input  wire logic [1:0]             i_sof_tmo_ie,
  // per endpoint events, bit d*8+ep
  input  wire udsf_pkg::udsf_ep2_t    i_ep_ack,
  input  wire udsf_pkg::udsf_ep2_t    i_ep_stall,
  input  wire udsf_pkg::udsf_ep2_t    i_ep_tmo,
  input  wire udsf_pkg::udsf_ep2_t    i_ep_in_err,
  input  wire udsf_pkg::udsf_ep2_t    i_ep_out_err,
  input  wire udsf_pkg::udsf_ep2_t    i_ep_nak,
  input  wire udsf_pkg::udsf_ep2_t    i_ep_nak_ie,
  // timeout pulse per instance, for the interrupt logic outside
  output logic [1:0]                  o_sof_timeout
);
  import udsf_pkg::*;

  // 12 MHz tick from the 125 MHz core clock by fractional accumulation
  logic [7:0] acc_q;
  logic [7:0] acc_sum;
  logic       tick_q;

  assign acc_sum = acc_q + `UDSF_TICK_MHZ;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      acc_q  <= `UDSF_ACC_RESET;
      tick_q <= 1'b0;
    end else if (acc_sum >= `UDSF_CORE_MHZ) begin
      acc_q  <= acc_sum - `UDSF_CORE_MHZ;
      tick_q <= 1'b1;
    end else begin
      acc_q  <= acc_sum;
      tick_q <= 1'b0;
    end
  end

  // OTG edge detectors; primed after reset so the first sample is no edge
  logic prime_q;
  logic vbus_prev_q;
  logic id_prev_q;
  logic vbus_edge;
  logic id_edge;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      prime_q     <= 1'b0;
      vbus_prev_q <= 1'b0;
      id_prev_q   <= 1'b0;
    end else begin
      prime_q     <= 1'b1;
      vbus_prev_q <= i_vbus_valid;
      id_prev_q   <= i_otg_id;
    end
  end

  assign vbus_edge = prime_q & (vbus_prev_q ^ i_vbus_valid) & i_vbus_ie;
  assign id_edge   = prime_q & (id_prev_q ^ i_otg_id) & i_id_ie;

  // per instance register state, unpacked so each instance drives its own
  udsf_word_t  stat_q [2];
  udsf_frame_t frame_q [2];
  logic [2:0]  tcnt_q [2];
  logic [1:0]  tflag_q;
  logic [1:0]  tmo_pulse;
  logic [1:0]  tmo_q;

  genvar d;
  generate
    for (d = 0; d < 2; d++) begin : g_dev
      localparam udsf_word_t STAT_A  = (d == 0) ? `UDSF_STATUS_ADDR0 : `UDSF_STATUS_ADDR1;
      localparam udsf_word_t COUNT_A = (d == 0) ? `UDSF_COUNT_ADDR0 : `UDSF_COUNT_ADDR1;
      localparam udsf_word_t MASK    = (d == 0) ? `UDSF_ST_MASK_DEV1 : `UDSF_ST_MASK_DEV2;

      logic [7:0]  ep_evt;
      udsf_word_t  set_vec;
      udsf_word_t  clr_vec;
      logic        stat_wr;
      logic        count_wr;

      assign stat_wr  = i_hp_wr & (i_hp_addr == STAT_A);
      assign count_wr = i_hp_wr & (i_hp_addr == COUNT_A);

      assign ep_evt = i_ep_ack[d*8 +: 8] | i_ep_stall[d*8 +: 8]
                    | i_ep_tmo[d*8 +: 8] | i_ep_in_err[d*8 +: 8]
                    | i_ep_out_err[d*8 +: 8]
                    | (i_ep_nak[d*8 +: 8] & i_ep_nak_ie[d*8 +: 8]);

      always_comb begin
        set_vec = `UDSF_WORD_ZERO;
        set_vec[`UDSF_ST_EP_LSB +: `UDSF_EP_NUM] = ep_evt;
        set_vec[`UDSF_ST_SOF_BIT] = i_sof_eop[d];
        set_vec[`UDSF_ST_RST_BIT] = i_usb_reset[d];
        if (d == 0) begin
          set_vec[`UDSF_ST_VBUS_BIT] = vbus_edge;
          set_vec[`UDSF_ST_ID_BIT]   = id_edge;
        end
      end

      // reserved positions, and OTG bits of the second instance, never hold
      // a one whatever software writes there
      assign clr_vec = stat_wr ? i_hp_wdata : `UDSF_WORD_ZERO;

      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          stat_q[d] <= `UDSF_ST_RESET;
        end else begin
          stat_q[d] <= ((stat_q[d] & ~clr_vec) | set_vec) & MASK;
        end
      end

      // frame field follows full speed SOF packets only
      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          frame_q[d] <= `UDSF_FRAME_RESET;
        end else if (i_sof_frame_vld[d] && !i_low_speed[d]) begin
          frame_q[d] <= i_sof_frame[d];
        end
      end

      udsf_sof_timer u_timer (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_tick     (tick_q),
        .i_restart  (i_sof_eop[d]),
        .i_load     (count_wr),
        .i_load_val (i_hp_wdata[`UDSF_COUNT_MSB:0]),
        .o_timeout  (tmo_pulse[d])
      );

      // a timeout in the same cycle as an SOF/EOP is kept, not lost
      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          tcnt_q[d]  <= `UDSF_FR_CNT_ZERO;
          tflag_q[d] <= 1'b0;
        end else if (i_sof_tmo_ie[d]) begin
          if (tmo_pulse[d]) begin
            tflag_q[d] <= 1'b1;
            if (tcnt_q[d] != `UDSF_FR_CNT_MAX) begin
              tcnt_q[d] <= tcnt_q[d] + `UDSF_FR_CNT_ONE;
            end
          end else if (i_sof_eop[d]) begin
            tcnt_q[d]  <= `UDSF_FR_CNT_ZERO;
            tflag_q[d] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tmo_q <= 2'h0;
    end else begin
      tmo_q <= tmo_pulse & i_sof_tmo_ie;
    end
  end

  assign o_sof_timeout = tmo_q;

  // read port; the count and unmapped locations read zero
  udsf_word_t rdata_d;
  udsf_word_t rdata_q;
  logic       rvalid_q;

  function automatic udsf_word_t frame_word(input logic        flag,
                                            input logic [2:0]  cnt,
                                            input udsf_frame_t fr);
    udsf_word_t w;
    w = `UDSF_WORD_ZERO;
    w[`UDSF_FR_TMO_BIT] = flag;
    w[`UDSF_FR_CNT_MSB:`UDSF_FR_CNT_LSB] = cnt;
    w[`UDSF_FR_FRAME_MSB:0] = fr;
    return w;
  endfunction : frame_word

  always_comb begin
    if (i_hp_addr == `UDSF_STATUS_ADDR0) begin
      rdata_d = stat_q[0];
    end else if (i_hp_addr == `UDSF_STATUS_ADDR1) begin
      rdata_d = stat_q[1];
    end else if (i_hp_addr == `UDSF_FRAME_ADDR0) begin
      rdata_d = frame_word(tflag_q[0], tcnt_q[0], frame_q[0]);
    end else if (i_hp_addr == `UDSF_FRAME_ADDR1) begin
      rdata_d = frame_word(tflag_q[1], tcnt_q[1], frame_q[1]);
    end else begin
      rdata_d = `UDSF_WORD_ZERO;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rdata_q  <= `UDSF_WORD_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= i_hp_rd;
      if (i_hp_rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign o_hp_rdata  = rdata_q;
  assign o_hp_rvalid = rvalid_q;
endmodule : udsf_status_frame

// file: shared/udsf_map.svh
/*
  Address map, field positions, reset values and timing figures for the
  device status and frame tracking registers.
  Assumes byte addresses on the parallel host port.
*/
`ifndef UDSF_MAP_SVH
`define UDSF_MAP_SVH

`define UDSF_STATUS_ADDR0   16'hc090
`define UDSF_STATUS_ADDR1   16'hc0b0
`define UDSF_FRAME_ADDR0    16'hc092
`define UDSF_FRAME_ADDR1    16'hc0b2
`define UDSF_COUNT_ADDR0    16'hc094
`define UDSF_COUNT_ADDR1    16'hc0b4

`define UDSF_ST_VBUS_BIT    15
`define UDSF_ST_ID_BIT      14
`define UDSF_ST_SOF_BIT     9
`define UDSF_ST_RST_BIT     8
`define UDSF_ST_EP_LSB      0
`define UDSF_EP_NUM         8

`define UDSF_ST_MASK_DEV1   16'hc3ff
`define UDSF_ST_MASK_DEV2   16'h03ff
`define UDSF_ST_RESET       16'h0000

`define UDSF_FR_TMO_BIT     15
`define UDSF_FR_CNT_LSB     12
`define UDSF_FR_CNT_MSB     14
`define UDSF_FR_FRAME_MSB   10
`define UDSF_FR_CNT_MAX     3'h7
`define UDSF_FR_CNT_ONE     3'h1
`define UDSF_FR_CNT_ZERO    3'h0
`define UDSF_FRAME_RESET    11'h000

`define UDSF_COUNT_MSB      13
`define UDSF_COUNT_RESET    14'h2ee0
`define UDSF_COUNT_ONE      14'h0001

`define UDSF_CORE_MHZ       8'h7d
`define UDSF_TICK_MHZ       8'h0c
`define UDSF_ACC_RESET      8'h00

`define UDSF_WORD_ZERO      16'h0000

`endif

// file: shared/udsf_pkg.sv
/*
  Types shared by the status/frame register block and its interval timer.
  Assumes udsf_map.svh supplies the numeric constants.
*/
package udsf_pkg;
  typedef logic [15:0]       udsf_word_t;
  typedef logic [13:0]       udsf_count_t;
  typedef logic [10:0]       udsf_frame_t;
  typedef logic [1:0][10:0]  udsf_frame2_t;
  typedef logic [15:0]       udsf_ep2_t;
  typedef enum logic [0:0] {
    UDSF_DEV_FIRST,
    UDSF_DEV_SECOND
  } udsf_dev_e;
endpackage : udsf_pkg
